// file: inc/pcmd_fn_if.sv
// Per-function view of one command register copy.
// Assumes one instance per function, joined by the bank top.
`timescale 1ns/10ps
interface pcmd_fn_if;
  logic wr_en;
  logic [15:0] wr_data;
  logic [1:0] wr_be;
  logic rev23;
  logic [15:0] value;
  modport bank (output wr_en, output wr_data, output wr_be, output rev23, input value);
  modport reg_side (input wr_en, input wr_data, input wr_be, input rev23, output value);
endinterface : pcmd_fn_if

// file: inc/pcmd_pkg.sv
// Constants for the per-function PCI command register bank.
// Assumes a configuration-access front end on the PCI clock that decodes function and offset.
// What this block does
// - Each of the three functions has its own command register, with no bit shared between copies.
// - The system-error and parity enables are ORed across functions inside, yet each copy reads back as written.
// - Bits 15 to 11 and bit 7 always read as zero.
// - A set interrupt mask at bit 10 stops the function from asserting INTx; clear allows it.
// - When the general control enable bit is 0 the interrupt mask reads zero and ignores writes.
// - Bit 9 reads zero and no fast back-to-back transaction is ever generated.
// - Bit 8 gates the SERR output driver, disabled when 0.
// - An address parity error drives SERR only when both bit 8 and bit 6 are set.
// - With bit 6 clear parity errors are ignored; set, data errors go to PERR and, with bit 8 also set, address errors to SERR.
// - With bit 5 set palette writes are not claimed but their data is captured; clear, decoded normally.
// - Bit 4 reads zero, ignores writes, and the initiator uses plain memory write commands.
// - Bit 3 reads zero, ignores writes, and special cycles are never answered.
// - The function requests and owns the bus as initiator only while bit 2 is set.
// - The function claims memory cycles only while bit 1 is set.
// - The function claims I/O cycles only while bit 0 is set.
package pcmd_pkg;
  localparam int PCMD_NFUNC = 3;
  localparam logic [7:0] PCMD_OFFSET = 8'h04;
  localparam logic [15:0] PCMD_RESET = 16'h0000;
  localparam int PCMD_B_IO = 0;
  localparam int PCMD_B_MEM = 1;
  localparam int PCMD_B_INIT = 2;
  localparam int PCMD_B_SNOOP = 5;
  localparam int PCMD_B_PAR = 6;
  localparam int PCMD_B_SERR = 8;
  localparam int PCMD_B_INTMASK = 10;
  // Writable bits; all others are hardwired zero
  localparam logic [15:0] PCMD_WMASK = 16'h0567;
  localparam logic [15:0] PCMD_INTMASK_BIT = 16'h0400;
  // Plain memory write command code used by the initiator
  localparam logic [3:0] PCMD_CMD_MEMWR = 4'h7;
  // Write-and-invalidate request code, folded into a plain write
  localparam logic [3:0] PCMD_CMD_MWI = 4'hF;
endpackage : pcmd_pkg

// file: rtl/pcmd_bank.sv
// Command register bank for three PCI functions with the gating it feeds.
// Assumes config decode, target, initiator and parity logic are on the same PCI clock.
`timescale 1ns/10ps
module pcmd_bank
  import pcmd_pkg::*;
#(
  parameter int NFUNC = PCMD_NFUNC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [1:0] cfg_func,
  input wire logic [7:0] cfg_offset,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // General control enable, one per function
  input wire logic [NFUNC-1:0] rev23_features_enable,
  // Requests from function logic
  input wire logic [NFUNC-1:0] int_req,
  input wire logic [NFUNC-1:0] init_req,
  input wire logic [NFUNC-1:0] mem_hit,
  input wire logic [NFUNC-1:0] io_hit,
  input wire logic [NFUNC-1:0] palette_wr,
  input wire logic addr_par_err,
  input wire logic data_par_err,
  input wire logic [3:0] init_cmd_req,
  // Gated results
  output logic [NFUNC-1:0] intx_assert,
  output logic [NFUNC-1:0] bus_request,
  output logic [NFUNC-1:0] mem_claim,
  output logic [NFUNC-1:0] io_claim,
  output logic [NFUNC-1:0] palette_capture,
  output logic serr_assert,
  output logic perr_assert,
  output logic serr_oe_n,
  output logic [3:0] init_cmd,
  output logic fast_b2b,
  output logic special_claim
);
  logic [15:0] value [NFUNC];
  logic [NFUNC-1:0] syserr_drive_enable;
  logic [NFUNC-1:0] par_en;
  logic serr_any;
  logic par_any;

  genvar g;
  generate
    for (g = 0; g < NFUNC; g++)
    begin : g_fn
      pcmd_fn_if fn ();
      assign fn.wr_en = cfg_wr && cfg_offset == PCMD_OFFSET && cfg_func == 2'(g);
      assign fn.wr_data = cfg_wdata;
      assign fn.wr_be = cfg_be;
      assign fn.rev23 = rev23_features_enable[g];
      assign value[g] = fn.value;
      assign syserr_drive_enable[g] = fn.value[PCMD_B_SERR];
      assign par_en[g] = fn.value[PCMD_B_PAR];
      pcmd_fn_reg u_reg (.clk_sys(clk_sys), .rst(rst), .fn(fn.reg_side));
    end
  endgenerate

  // Error enables act for the device as a whole
  assign serr_any = |syserr_drive_enable;
  assign par_any = |par_en;

  // Idle or missed reads return zero, so read data stands for one cycle only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cfg_rdata <= 16'h0000;
    else if (cfg_rd && cfg_offset == PCMD_OFFSET && cfg_func < 2'(NFUNC))
      cfg_rdata <= value[cfg_func];
    else
      cfg_rdata <= 16'h0000;
  end

  // Every gate uses the value as read back, so a hidden mask bit never masks
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      intx_assert <= '0;
      bus_request <= '0;
      mem_claim <= '0;
      io_claim <= '0;
      palette_capture <= '0;
    end
    else
    begin
      for (int i = 0; i < NFUNC; i++)
      begin
        intx_assert[i] <= int_req[i] && !value[i][PCMD_B_INTMASK];
        bus_request[i] <= init_req[i] && value[i][PCMD_B_INIT];
        // Snooped palette writes are captured, never claimed
        mem_claim[i] <= mem_hit[i] && value[i][PCMD_B_MEM]
          && !(palette_wr[i] && value[i][PCMD_B_SNOOP]);
        io_claim[i] <= io_hit[i] && value[i][PCMD_B_IO]
          && !(palette_wr[i] && value[i][PCMD_B_SNOOP]);
        palette_capture[i] <= palette_wr[i] && value[i][PCMD_B_SNOOP];
      end
    end
  end

  // Driver enable follows the report itself; the pin is pulled only while reporting
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      serr_assert <= 1'b0;
      perr_assert <= 1'b0;
      serr_oe_n <= 1'b1;
    end
    else
    begin
      serr_assert <= addr_par_err && serr_any && par_any;
      perr_assert <= data_par_err && par_any;
      serr_oe_n <= !(addr_par_err && serr_any && par_any);
    end
  end

  // Initiator command and the two features this device never offers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      init_cmd <= PCMD_CMD_MEMWR;
      fast_b2b <= 1'b0;
      special_claim <= 1'b0;
    end
    else
    begin
      // Write-and-invalidate folds to plain memory write
      init_cmd <= (init_cmd_req == PCMD_CMD_MWI) ? PCMD_CMD_MEMWR : init_cmd_req;
      fast_b2b <= 1'b0;
      special_claim <= 1'b0;
    end
  end

  // Device-wide error path, function 0 initiator and mask gates, and fixed behaviour
  a_serr_gate: assert property (@(posedge clk_sys) disable iff (rst)
    serr_assert |-> $past(serr_any && par_any && addr_par_err)) else $error("serr ungated");
  a_perr_ignore: assert property (@(posedge clk_sys) disable iff (rst)
    (!par_any && data_par_err) |=> !perr_assert) else $error("perr while disabled");
  a_init_gate: assert property (@(posedge clk_sys) disable iff (rst)
    bus_request[0] |-> $past(value[0][PCMD_B_INIT])) else $error("bus request ungated");
  a_int_mask: assert property (@(posedge clk_sys) disable iff (rst)
    (int_req[0] && value[0][PCMD_B_INTMASK]) |=> !intx_assert[0]) else $error("intx leaked");
  a_no_fbb: assert property (@(posedge clk_sys) disable iff (rst)
    !fast_b2b && !special_claim) else $error("fbb or special cycle");

  // The driver may only turn on when some copy enables it
  a_serr_driver: assert property (@(posedge clk_sys) disable iff (rst)
    !serr_any |=> serr_oe_n)
    else $error("serr driver on while disabled");
  a_serr_needs_par: assert property (@(posedge clk_sys) disable iff (rst)
    !par_any |=> !serr_assert)
    else $error("serr without parity enable");
  // Enables set in different copies still combine
  a_serr_report: assert property (@(posedge clk_sys) disable iff (rst)
    (addr_par_err && serr_any && par_any) |=> (serr_assert && !serr_oe_n))
    else $error("address parity error not reported");
  a_perr_report: assert property (@(posedge clk_sys) disable iff (rst)
    (data_par_err && par_any) |=> perr_assert)
    else $error("data parity error not reported");
  a_perr_gate: assert property (@(posedge clk_sys) disable iff (rst)
    perr_assert |-> $past(par_any && data_par_err))
    else $error("perr without cause");
  a_mwi_fold: assert property (@(posedge clk_sys) disable iff (rst)
    (init_cmd_req == PCMD_CMD_MWI) |=> (init_cmd == PCMD_CMD_MEMWR))
    else $error("write and invalidate issued");
  a_rdata_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (cfg_rdata & ~PCMD_WMASK) == 16'h0000)
    else $error("reserved bit read as one");

  // Per-copy checks; each function is judged only by its own bits
  genvar c;
  generate
    for (c = 0; c < NFUNC; c++)
    begin : g_chk
      a_mem_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (mem_hit[c] && !value[c][PCMD_B_MEM]) |=> !mem_claim[c])
        else $error("memory cycle claimed while disabled");
      a_io_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (io_hit[c] && !value[c][PCMD_B_IO]) |=> !io_claim[c])
        else $error("port cycle claimed while disabled");
      a_bus_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (init_req[c] && !value[c][PCMD_B_INIT]) |=> !bus_request[c])
        else $error("bus requested while initiator off");
      a_intx_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (int_req[c] && value[c][PCMD_B_INTMASK]) |=> !intx_assert[c])
        else $error("interrupt asserted while masked");
      a_intx_pass: assert property (@(posedge clk_sys) disable iff (rst)
        (int_req[c] && !value[c][PCMD_B_INTMASK]) |=> intx_assert[c])
        else $error("interrupt lost while unmasked");
      a_snoop_capture: assert property (@(posedge clk_sys) disable iff (rst)
        (palette_wr[c] && value[c][PCMD_B_SNOOP])
          |=> (palette_capture[c] && !mem_claim[c] && !io_claim[c]))
        else $error("snooped palette write claimed");
      a_snoop_off: assert property (@(posedge clk_sys) disable iff (rst)
        !value[c][PCMD_B_SNOOP] |=> !palette_capture[c])
        else $error("palette captured while snoop off");
      // Read data stands for one cycle after the read edge
      a_read_back: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_rd && cfg_offset == PCMD_OFFSET && cfg_func == 2'(c))
          |=> (cfg_rdata == $past(value[c])))
        else $error("read data not from own copy");
      a_mask_read: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_rd && cfg_offset == PCMD_OFFSET && cfg_func == 2'(c) && !rev23_features_enable[c])
          |=> !cfg_rdata[PCMD_B_INTMASK])
        else $error("interrupt mask read while gated off");
      // Bit 10 may follow its gate, so it is left out here
      a_copy_apart: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg_wr && cfg_func != 2'(c))
          |=> ((value[c] & ~PCMD_INTMASK_BIT) == $past(value[c] & ~PCMD_INTMASK_BIT)))
        else $error("copy changed by another function");
    end
  endgenerate
endmodule : pcmd_bank

// file: rtl/pcmd_fn_reg.sv
// One function's command register copy.
// Assumes writes come from the bank top on the PCI clock.
`timescale 1ns/10ps
module pcmd_fn_reg
  import pcmd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bank side
  pcmd_fn_if.reg_side fn
);
  logic [15:0] cmd;
  logic [15:0] wmask;

  always_comb
  begin
    wmask = PCMD_WMASK;
    if (!fn.rev23)
      wmask = wmask & ~PCMD_INTMASK_BIT;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cmd <= PCMD_RESET;
    else
    begin
      if (fn.wr_en && fn.wr_be[0])
        cmd[7:0] <= fn.wr_data[7:0] & wmask[7:0];
      if (fn.wr_en && fn.wr_be[1])
        cmd[15:8] <= fn.wr_data[15:8] & wmask[15:8];
      else if (!fn.rev23)
        cmd[PCMD_B_INTMASK] <= 1'b0;
    end
  end

  // Mask reads zero while the general control enable is off
  assign fn.value = fn.rev23 ? cmd : (cmd & ~PCMD_INTMASK_BIT);

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (fn.value & ~PCMD_WMASK) == 16'h0000) else $error("reserved bit set");
  a_mask_gated: assert property (@(posedge clk_sys) disable iff (rst)
    !fn.rev23 |-> !fn.value[PCMD_B_INTMASK]) else $error("mask visible while off");
  a_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
    (fn.wr_en && fn.wr_be[0]) |=> fn.value[PCMD_B_MEM] == $past(fn.wr_data[PCMD_B_MEM]))
    else $error("memory enable write lost");
endmodule : pcmd_fn_reg

// file: testbench/pcmd_host.sv
// Configuration host model for the command register bank.
// Assumes read data is registered one cycle after the read edge.
`timescale 1ns/10ps
module pcmd_host
(
  // Clock
  input wire logic clk_sys,
  // Configuration access
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [1:0] cfg_func,
  output logic [7:0] cfg_offset,
  output logic [1:0] cfg_be,
  output logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata
);
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_func = 2'h0;
    cfg_offset = 8'h00;
    cfg_be = 2'h0;
    cfg_wdata = 16'h0000;
  end

  // One access per call; write data is inverted afterwards so stale data never looks valid
  task automatic access(input logic wr, input logic [1:0] f, input logic [7:0] off,
                        input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_sys);
    #1;
    cfg_wr = wr;
    cfg_rd = !wr;
    cfg_func = f;
    cfg_offset = off;
    cfg_be = 2'h3;
    cfg_wdata = d;
    @(posedge clk_sys);
    #1;
    q = cfg_rdata;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = ~d;
  endtask : access
endmodule : pcmd_host

// file: testbench/test_pci_function_command_reg.sv
// Self-checking bench for the three-function command register bank.
// Assumes the host model drives configuration cycles one at a time.
`timescale 1ns/10ps
module test_pci_function_command_reg;
  import pcmd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr, cfg_rd;
  logic [1:0] cfg_func, cfg_be;
  logic [7:0] cfg_offset;
  logic [15:0] cfg_wdata, cfg_rdata, q;
  logic [2:0] rev23_features_enable = 3'h0, int_req = 3'h0, init_req = 3'h0;
  logic [2:0] mem_hit = 3'h0, io_hit = 3'h0, palette_wr = 3'h0;
  logic [2:0] intx_assert, bus_request, mem_claim, io_claim, palette_capture;
  logic addr_par_err = 1'b0, data_par_err = 1'b0;
  logic serr_assert, perr_assert, serr_oe_n, fast_b2b, special_claim;
  logic [3:0] init_cmd_req = 4'h0, init_cmd;
  int n_fail = 0, num_checks = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  pcmd_host host (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func),
    .cfg_offset(cfg_offset), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  pcmd_bank dut (.clk_sys(clk_sys), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_func(cfg_func), .cfg_offset(cfg_offset), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .rev23_features_enable(rev23_features_enable), .int_req(int_req),
    .init_req(init_req), .mem_hit(mem_hit), .io_hit(io_hit), .palette_wr(palette_wr),
    .addr_par_err(addr_par_err), .data_par_err(data_par_err), .init_cmd_req(init_cmd_req),
    .intx_assert(intx_assert), .bus_request(bus_request), .mem_claim(mem_claim),
    .io_claim(io_claim), .palette_capture(palette_capture), .serr_assert(serr_assert),
    .perr_assert(perr_assert), .serr_oe_n(serr_oe_n), .init_cmd(init_cmd),
    .fast_b2b(fast_b2b), .special_claim(special_claim));

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Gated outputs pass a register and an output flop
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // Outputs are judged while reset still stands, then each copy is read
  task automatic t_reset;
    repeat (20) @(posedge clk_sys);
    #1;
    chk("reset rdata", 16'h0000, cfg_rdata);
    chk("reset gates", 16'h0000, {1'b0, intx_assert, bus_request, mem_claim, io_claim,
      palette_capture});
    chk("reset misc", 16'h0017, {7'h0, serr_assert, perr_assert, fast_b2b, special_claim,
      serr_oe_n, init_cmd});
    rst = 1'b0;
    for (int f = 0; f < 3; f++)
    begin
      host.access(1'b0, f[1:0], PCMD_OFFSET, 16'h0000, q);
      chk("reset read", 16'h0000, q);
    end
  endtask : t_reset

  task automatic t_masks;
    rev23_features_enable = 3'h5;
    host.access(1'b1, 2'h0, PCMD_OFFSET, 16'hFFFF, q);
    host.access(1'b0, 2'h0, PCMD_OFFSET, 16'h0000, q);
    chk("f0 read", 16'h0567, q);
    host.access(1'b0, 2'h1, PCMD_OFFSET, 16'h0000, q);
    chk("f1 untouched", 16'h0000, q);
    host.access(1'b1, 2'h1, PCMD_OFFSET, 16'hFFFF, q);
    host.access(1'b0, 2'h1, PCMD_OFFSET, 16'h0000, q);
    chk("f1 no mask", 16'h0167, q);
    host.access(1'b0, 2'h0, 8'h08, 16'h0000, q);
    chk("unmapped", 16'h0000, q);
  endtask : t_masks

  task automatic t_gating;
    {int_req, init_req, mem_hit, io_hit, palette_wr} = 15'h7FFF;
    {addr_par_err, data_par_err, init_cmd_req} = 6'h3F;
    settle();
    chk("gates", 16'h6603, {1'b0, intx_assert, bus_request, mem_claim, io_claim,
      palette_capture});
    chk("errs", 16'hC007, {serr_assert, perr_assert, serr_oe_n, fast_b2b, special_claim,
      3'h0, 4'h0, init_cmd});
    palette_wr = 3'h0;
    init_cmd_req = 4'h6;
    settle();
    chk("claims", 16'h00D8, {7'h0, mem_claim, io_claim, palette_capture});
    chk("cmd pass", 16'h0006, {12'h0, init_cmd});
    host.access(1'b1, 2'h0, PCMD_OFFSET, 16'h0000, q);
    host.access(1'b1, 2'h1, PCMD_OFFSET, 16'h0040, q);
    host.access(1'b1, 2'h2, PCMD_OFFSET, 16'h0100, q);
    settle();
    chk("ored", 16'h6000, {1'b0, serr_assert, perr_assert, serr_oe_n, bus_request, 9'h0});
    host.access(1'b1, 2'h1, PCMD_OFFSET, 16'h0000, q);
    settle();
    chk("par off", 16'h2000, {serr_assert, perr_assert, serr_oe_n, 13'h0});
    host.access(1'b0, 2'h2, PCMD_OFFSET, 16'h0000, q);
    chk("f2 read", 16'h0100, q);
  endtask : t_gating

  // A reset in mid-run must clear a copy that was written
  task automatic t_rerun;
    host.access(1'b1, 2'h2, PCMD_OFFSET, 16'hFFFF, q);
    host.access(1'b0, 2'h2, PCMD_OFFSET, 16'h0000, q);
    chk("f2 before reset", 16'h0567, q);
    rst = 1'b1;
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    host.access(1'b0, 2'h2, PCMD_OFFSET, 16'h0000, q);
    chk("f2 after reset", 16'h0000, q);
    settle();
    chk("intx after reset", 16'h0007, {13'h0, intx_assert});
  endtask : t_rerun

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    t_reset();
    t_masks();
    t_gating();
    t_rerun();
    summarize();
  end
endmodule : test_pci_function_command_reg
